/* design/scd_pkg.sv */
// Shared constants and types for the axis drive and its supervising controller
package scd_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 20;
  localparam int POLL_TIME_US = 100;
  localparam int POLL_CYC     = POLL_TIME_US * CLK_MHZ;
  localparam int POLL_W       = $clog2(POLL_CYC);

  // ----------------------------------------
  // Link command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_WR_MODE1  = 8'h01;
  localparam logic [7:0] CMD_WR_MODE2  = 8'h02;
  localparam logic [7:0] CMD_WR_PULSES = 8'h03;
  localparam logic [7:0] CMD_WR_INIT   = 8'h04;
  localparam logic [7:0] CMD_WR_SPEED  = 8'h05;
  localparam logic [7:0] CMD_WR_STEP   = 8'h06;
  localparam logic [7:0] CMD_FIX_POS   = 8'h20;
  localparam logic [7:0] CMD_FIX_NEG   = 8'h21;
  localparam logic [7:0] CMD_DEC_STOP  = 8'h26;
  localparam logic [7:0] CMD_SUD_STOP  = 8'h27;

  // ----------------------------------------
  // Device register fields
  // ----------------------------------------
  localparam int ST_ACC        = 2;
  localparam int ST_CONST      = 3;
  localparam int ST_DEC        = 4;
  localparam int ST_LIM_POS    = 12;
  localparam int ST_LIM_NEG    = 13;
  localparam int FACT_CEND     = 5;
  localparam int MODE1_CEND_EN = 13;
  localparam int MODE2_LIM_DEC = 2;

  // ----------------------------------------
  // Controller registers on APB
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_PULSES   = 8'h04;
  localparam logic [7:0] REG_INIT     = 8'h08;
  localparam logic [7:0] REG_SPEED    = 8'h0C;
  localparam logic [7:0] REG_STEP     = 8'h10;
  localparam logic [7:0] REG_SOFTP    = 8'h14;
  localparam logic [7:0] REG_SOFTN    = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1C;
  localparam logic [7:0] REG_IRQ_ST   = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_POS      = 8'h28;

  localparam int CTL_START  = 0;
  localparam int CTL_DIR    = 1;
  localparam int CTL_DSTOP  = 2;
  localparam int CTL_SSTOP  = 3;
  localparam int CTL_LIMDEC = 4;

  localparam int STS_DRV    = 16;
  localparam int STS_BUSY   = 17;
  localparam int STS_PROHIB = 18;

  localparam int EV_DONE    = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_RECOVER = 2;
  localparam int EV_CEND    = 3;
  localparam int NUM_EV     = 4;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [31:0] RST_PULSES     = 32'h0000_0000;
  localparam logic [15:0] RST_INIT       = 16'h0100;
  localparam logic [15:0] RST_SPEED      = 16'h1000;
  localparam logic [15:0] RST_STEP       = 16'h0010;
  localparam logic [31:0] RST_SOFTP      = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_SOFTN      = 32'h8000_0000;
  localparam logic [31:0] MIN_SEG_PULSES = 32'h0000_0002;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ACC, PH_CONST, PH_DEC, PH_LATE, PH_FAULT
  } scd_phase_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_LOAD, HS_RUN
  } scd_hstate_t;

endpackage

/* design/scd_link_if.sv */
// Link between the supervising controller and the axis drive
`timescale 1ns/100ps
interface scd_link_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [31:0] cmd_data;
  logic        fact_ack;
  logic [15:0] axis_status;
  logic [15:0] irq_factor;
  logic        drive_active;
  logic        irq;
  logic [15:0] cur_speed;
  logic [31:0] logical_pos;

  modport dev (
    input  cmd_valid, cmd_code, cmd_data, fact_ack,
    output axis_status, irq_factor, drive_active, irq, cur_speed, logical_pos
  );

  modport host (
    output cmd_valid, cmd_code, cmd_data, fact_ack,
    input  axis_status, irq_factor, drive_active, irq, cur_speed, logical_pos
  );
endinterface

/* design/scd_axis_dev.sv */
// Pulse-output axis with linear-ramp (trapezoidal) phases, stop commands and status flags
`timescale 1ns/100ps
module scd_axis_dev
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controller link
  scd_link_if.dev   lnk,
  // Hardware limits, active low pins
  input  wire logic lim_pos_n,
  input  wire logic lim_neg_n,
  // Pulse outputs
  output logic      pulse_out,
  output logic      dir_out
);

  scd_phase_t  phase_q, phase_d;
  logic [15:0] speed_q, speed_d, acc_q, acc_d;
  logic [31:0] remain_q, remain_d, ramp_q, ramp_d, pos_q, pos_d;
  logic [31:0] pulses_q, pulses_d;
  logic [15:0] mode1_q, mode1_d, mode2_q, mode2_d;
  logic [15:0] init_q, init_d, drive_q, drive_d, step_q, step_d;
  logic        dir_q, dir_d, pulse_q, pulse_d, cend_q, cend_d;
  logic [15:0] status_q, status_d;
  logic        lp_s1_q, lp_s2_q, ln_s1_q, ln_s2_q;
  logic [16:0] sum, up;
  logic        dstop, sstop, lim_hit, lim_dec, cend_set;

  // ----------------------------------------
  // Limit pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_s1_q <= 1'b1;
      lp_s2_q <= 1'b1;
      ln_s1_q <= 1'b1;
      ln_s2_q <= 1'b1;
    end else begin
      lp_s1_q <= lim_pos_n;
      lp_s2_q <= lp_s1_q;
      ln_s1_q <= lim_neg_n;
      ln_s2_q <= ln_s1_q;
    end
  end

  // ----------------------------------------
  // Drive sequencing
  // ----------------------------------------
  always_comb begin
    phase_d  = phase_q;
    speed_d  = speed_q;
    acc_d    = acc_q;
    remain_d = remain_q;
    ramp_d   = ramp_q;
    pos_d    = pos_q;
    pulses_d = pulses_q;
    mode1_d  = mode1_q;
    mode2_d  = mode2_q;
    init_d   = init_q;
    drive_d  = drive_q;
    step_d   = step_q;
    dir_d    = dir_q;
    pulse_d  = 1'b0;
    cend_set = 1'b0;
    sum      = {1'b0, acc_q} + {1'b0, speed_q};
    up       = {1'b0, speed_q} + {1'b0, step_q};
    dstop    = lnk.cmd_valid && (lnk.cmd_code == CMD_DEC_STOP);
    sstop    = lnk.cmd_valid && (lnk.cmd_code == CMD_SUD_STOP);
    lim_hit  = dir_q ? !ln_s2_q : !lp_s2_q;
    lim_dec  = lim_hit && mode2_q[MODE2_LIM_DEC];
    if (lnk.cmd_valid) begin
      case (lnk.cmd_code)
        CMD_WR_MODE1:  mode1_d  = lnk.cmd_data[15:0];
        CMD_WR_MODE2:  mode2_d  = lnk.cmd_data[15:0];
        CMD_WR_PULSES: pulses_d = lnk.cmd_data;
        CMD_WR_INIT:   init_d   = lnk.cmd_data[15:0];
        CMD_WR_SPEED:  drive_d  = lnk.cmd_data[15:0];
        CMD_WR_STEP:   step_d   = lnk.cmd_data[15:0];
        default: ;
      endcase
    end
    // Phase accumulator emits one pulse per overflow
    if (phase_q != PH_IDLE) begin
      acc_d = sum[15:0];
      if (sum[16]) begin
        pulse_d = 1'b1;
        pos_d   = dir_q ? pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
        if (remain_q != 32'h0000_0000) begin
          remain_d = remain_q - 32'h0000_0001;
        end
        if (phase_q == PH_ACC) begin
          ramp_d = ramp_q + 32'h0000_0001;
        end
      end
    end
    unique case (phase_q)
      PH_IDLE: begin
        speed_d = init_q;
        acc_d   = 16'h0000;
        if (lnk.cmd_valid && pulses_q != 32'h0000_0000 &&
            (lnk.cmd_code == CMD_FIX_POS || lnk.cmd_code == CMD_FIX_NEG)) begin
          phase_d  = PH_ACC;
          remain_d = pulses_q;
          ramp_d   = 32'h0000_0000;
          dir_d    = (lnk.cmd_code == CMD_FIX_NEG);
        end
      end
      PH_ACC: begin
        if (up >= {1'b0, drive_q}) begin
          speed_d = drive_q;
          phase_d = PH_CONST;
        end else begin
          speed_d = up[15:0];
        end
        if (remain_q <= ramp_q || dstop || lim_dec) begin
          phase_d = PH_DEC;
        end
        // Requested stop ramps down over the accelerated pulses
        if ((dstop || lim_dec) && ramp_q < remain_q) begin
          remain_d = ramp_q;
        end
      end
      PH_CONST: begin
        if (remain_q <= ramp_q || dstop || lim_dec) begin
          phase_d  = PH_DEC;
          cend_set = 1'b1;
        end
        // Requested stop ramps down over the accelerated pulses
        if ((dstop || lim_dec) && ramp_q < remain_q) begin
          remain_d = ramp_q;
        end
      end
      PH_DEC: begin
        if ({1'b0, speed_q} > {1'b0, init_q} + {1'b0, step_q}) begin
          speed_d = speed_q - step_q;
        end else begin
          speed_d = init_q;
        end
        if (remain_q == 32'h0000_0000) begin
          phase_d = PH_IDLE;
        end else if (dstop || lim_dec) begin
          phase_d = PH_LATE;
        end
      end
      PH_LATE: begin
        if (remain_q == 32'h0000_0000) begin
          cend_set = 1'b1;
          phase_d  = (speed_q > init_q) ? PH_FAULT : PH_IDLE;
        end
      end
      PH_FAULT: ;
    endcase
    if (phase_q != PH_IDLE && (sstop || (lim_hit && !mode2_q[MODE2_LIM_DEC]))) begin
      phase_d = PH_IDLE;
      speed_d = init_q;
    end
    cend_d = (cend_q && !lnk.fact_ack) || (cend_set && mode1_q[MODE1_CEND_EN]);
    status_d             = 16'h0000;
    status_d[ST_ACC]     = (phase_d == PH_ACC);
    status_d[ST_CONST]   = (phase_d == PH_CONST) || (phase_d == PH_LATE);
    status_d[ST_DEC]     = (phase_d == PH_DEC);
    status_d[ST_LIM_POS] = !lp_s2_q;
    status_d[ST_LIM_NEG] = !ln_s2_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q  <= PH_IDLE;
      speed_q  <= RST_INIT;
      acc_q    <= 16'h0000;
      remain_q <= 32'h0000_0000;
      ramp_q   <= 32'h0000_0000;
      pos_q    <= 32'h0000_0000;
      pulses_q <= RST_PULSES;
      mode1_q  <= 16'h0000;
      mode2_q  <= 16'h0000;
      init_q   <= RST_INIT;
      drive_q  <= RST_SPEED;
      step_q   <= RST_STEP;
      dir_q    <= 1'b0;
      pulse_q  <= 1'b0;
      cend_q   <= 1'b0;
      status_q <= 16'h0000;
    end else begin
      phase_q  <= phase_d;
      speed_q  <= speed_d;
      acc_q    <= acc_d;
      remain_q <= remain_d;
      ramp_q   <= ramp_d;
      pos_q    <= pos_d;
      pulses_q <= pulses_d;
      mode1_q  <= mode1_d;
      mode2_q  <= mode2_d;
      init_q   <= init_d;
      drive_q  <= drive_d;
      step_q   <= step_d;
      dir_q    <= dir_d;
      pulse_q  <= pulse_d;
      cend_q   <= cend_d;
      status_q <= status_d;
    end
  end

  assign lnk.drive_active = (phase_q != PH_IDLE);
  assign lnk.axis_status  = status_q;
  assign lnk.irq_factor   = {10'h000, cend_q, 5'h00};
  assign lnk.irq          = cend_q;
  assign lnk.cur_speed    = speed_q;
  assign lnk.logical_pos  = pos_q;
  assign pulse_out        = pulse_q;
  assign dir_out          = dir_q;

endmodule

/* design/scd_host_ctl.sv */
// Supervising controller: APB registers, drive start, stop guards and recovery
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
module scd_host_ctl
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq_out,
  // Axis link
  scd_link_if.host         lnk
);

  scd_hstate_t        st_q, st_d;
  logic [2:0]         ld_q, ld_d;
  logic [31:0]        pulses_q, pulses_d, softp_q, softp_d, softn_q, softn_d;
  logic [15:0]        init_q, init_d, speed_q, speed_d, step_q, step_d, judge_q, judge_d;
  logic               dir_q, dir_d, limdec_q, limdec_d;
  logic               prohib_q, prohib_d, stopped_q, stopped_d, chk_q, chk_d;
  logic [NUM_EV-1:0]  ist_q, ist_d, mask_q, mask_d, ev;
  logic [POLL_W-1:0]  poll_q, poll_d;
  logic               cv_q, cv_d, ack_q, ack_d, irq_q, irq_d;
  logic [7:0]         cc_q, cc_d;
  logic [31:0]        cd_q, cd_d, rd_q, rd_d;
  logic               rdy_q, rdy_d, err_q, err_d;
  logic               setup, wr, rd, mapped, tick, lim_fwd, flags0, fault, out_rng;
  logic signed [32:0] tgt;

  // ----------------------------------------
  // Bus, registers and supervision
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    ld_d      = ld_q;
    pulses_d  = pulses_q;
    softp_d   = softp_q;
    softn_d   = softn_q;
    init_d    = init_q;
    speed_d   = speed_q;
    step_d    = step_q;
    judge_d   = judge_q;
    dir_d     = dir_q;
    limdec_d  = limdec_q;
    prohib_d  = prohib_q;
    stopped_d = stopped_q;
    chk_d     = 1'b0;
    mask_d    = mask_q;
    poll_d    = poll_q;
    cv_d      = 1'b0;
    cc_d      = cc_q;
    cd_d      = cd_q;
    ack_d     = 1'b0;
    ev        = '0;
    setup     = psel && !penable;
    wr        = psel && penable && rdy_q && pwrite;
    rd        = psel && penable && rdy_q && !pwrite;
    mapped    = (paddr[1:0] == 2'b00) && (paddr <= REG_POS);
    lim_fwd   = dir_q ? lnk.axis_status[ST_LIM_NEG] : lnk.axis_status[ST_LIM_POS];
    flags0    = !lnk.axis_status[ST_ACC] && !lnk.axis_status[ST_CONST] &&
                !lnk.axis_status[ST_DEC];
    fault     = lnk.drive_active && lim_fwd && flags0;
    tick      = (poll_q == POLL_W'(POLL_CYC - 1));
    tgt = $signed({lnk.logical_pos[31], lnk.logical_pos}) +
          (pwdata[CTL_DIR] ? -$signed({1'b0, pulses_q}) : $signed({1'b0, pulses_q}));
    out_rng = (tgt > $signed({softp_q[31], softp_q})) ||
              (tgt < $signed({softn_q[31], softn_q}));
    rdy_d = setup;
    err_d = setup && !mapped;
    rd_d  = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        REG_CTRL:     rd_d = {27'h000_0000, limdec_q, 2'b00, dir_q, 1'b0};
        REG_PULSES:   rd_d = pulses_q;
        REG_INIT:     rd_d = {16'h0000, init_q};
        REG_SPEED:    rd_d = {16'h0000, speed_q};
        REG_STEP:     rd_d = {16'h0000, step_q};
        REG_SOFTP:    rd_d = softp_q;
        REG_SOFTN:    rd_d = softn_q;
        REG_STATUS:   rd_d = {13'h0000, prohib_q, st_q != HS_IDLE, lnk.drive_active,
                              lnk.axis_status};
        REG_IRQ_ST:   rd_d = {28'h000_0000, ist_q};
        REG_IRQ_MASK: rd_d = {28'h000_0000, mask_q};
        REG_POS:      rd_d = lnk.logical_pos;
        default: ;
      endcase
    end
    if (wr) begin
      case (paddr)
        REG_CTRL:     limdec_d = pwdata[CTL_LIMDEC];
        REG_PULSES:   pulses_d = pwdata;
        REG_INIT:     init_d   = pwdata[15:0];
        REG_SPEED:    speed_d  = pwdata[15:0];
        REG_STEP:     step_d   = pwdata[15:0];
        REG_SOFTP:    softp_d  = pwdata;
        REG_SOFTN:    softn_d  = pwdata;
        REG_IRQ_MASK: mask_d   = pwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
    unique case (st_q)
      HS_IDLE: begin
        poll_d = '0;
        if (wr && paddr == REG_CTRL && pwdata[CTL_START]) begin
          if (pulses_q < MIN_SEG_PULSES || out_rng) begin
            ev[EV_REFUSED] = 1'b1;
          end else begin
            st_d      = HS_LOAD;
            ld_d      = 3'd0;
            dir_d     = pwdata[CTL_DIR];
            prohib_d  = 1'b0;
            stopped_d = 1'b0;
            judge_d   = init_q + ((speed_q - init_q) >> 1);
          end
        end
      end
      HS_LOAD: begin
        cv_d = 1'b1;
        ld_d = ld_q + 3'd1;
        unique case (ld_q)
          3'd0: begin
            cc_d = CMD_WR_MODE1;
            cd_d = 32'h0000_0001 << MODE1_CEND_EN;
          end
          3'd1: begin
            cc_d = CMD_WR_MODE2;
            cd_d = {31'h0000_0000, limdec_q} << MODE2_LIM_DEC;
          end
          3'd2: begin
            cc_d = CMD_WR_PULSES;
            cd_d = pulses_q;
          end
          3'd3: begin
            cc_d = CMD_WR_INIT;
            cd_d = {16'h0000, init_q};
          end
          3'd4: begin
            cc_d = CMD_WR_SPEED;
            cd_d = {16'h0000, speed_q};
          end
          3'd5: begin
            cc_d = CMD_WR_STEP;
            cd_d = {16'h0000, step_q};
          end
          default: begin
            cc_d = dir_q ? CMD_FIX_NEG : CMD_FIX_POS;
            cd_d = 32'h0000_0000;
            st_d = HS_RUN;
          end
        endcase
      end
      HS_RUN: begin
        poll_d = tick ? '0 : poll_q + POLL_W'(1);
        if (fault && !stopped_q && (tick || chk_q)) begin
          cv_d             = 1'b1;
          cc_d             = CMD_SUD_STOP;
          stopped_d        = 1'b1;
          ev[EV_RECOVER]   = 1'b1;
        end else if (lnk.irq && lnk.irq_factor[FACT_CEND] && !ack_q) begin
          prohib_d     = 1'b1;
          ack_d        = 1'b1;
          chk_d        = 1'b1;
          ev[EV_CEND]  = 1'b1;
          cv_d         = 1'b1;
          cc_d         = CMD_WR_MODE1;
          cd_d         = 32'h0000_0000;
        end else if (!lnk.drive_active && !cv_q) begin
          // Late end interrupt is taken before done
          st_d          = HS_IDLE;
          ev[EV_DONE]   = 1'b1;
        end else if (wr && paddr == REG_CTRL && pwdata[CTL_SSTOP]) begin
          cv_d = 1'b1;
          cc_d = CMD_SUD_STOP;
        end else if (wr && paddr == REG_CTRL && pwdata[CTL_DSTOP]) begin
          if (!prohib_q && lnk.cur_speed >= judge_q &&
              (lnk.axis_status[ST_ACC] || lnk.axis_status[ST_CONST])) begin
            cv_d = 1'b1;
            cc_d = CMD_DEC_STOP;
          end else begin
            ev[EV_REFUSED] = 1'b1;
          end
        end
      end
    endcase
    // Event set wins over read clear
    ist_d = ((rd && paddr == REG_IRQ_ST) ? '0 : ist_q) | ev;
    irq_d = |(ist_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= HS_IDLE;
      ld_q      <= 3'd0;
      pulses_q  <= RST_PULSES;
      softp_q   <= RST_SOFTP;
      softn_q   <= RST_SOFTN;
      init_q    <= RST_INIT;
      speed_q   <= RST_SPEED;
      step_q    <= RST_STEP;
      judge_q   <= RST_INIT;
      dir_q     <= 1'b0;
      limdec_q  <= 1'b0;
      prohib_q  <= 1'b0;
      stopped_q <= 1'b0;
      chk_q     <= 1'b0;
      ist_q     <= '0;
      mask_q    <= '0;
      poll_q    <= '0;
      cv_q      <= 1'b0;
      cc_q      <= 8'h00;
      cd_q      <= 32'h0000_0000;
      ack_q     <= 1'b0;
      irq_q     <= 1'b0;
      rd_q      <= 32'h0000_0000;
      rdy_q     <= 1'b0;
      err_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      ld_q      <= ld_d;
      pulses_q  <= pulses_d;
      softp_q   <= softp_d;
      softn_q   <= softn_d;
      init_q    <= init_d;
      speed_q   <= speed_d;
      step_q    <= step_d;
      judge_q   <= judge_d;
      dir_q     <= dir_d;
      limdec_q  <= limdec_d;
      prohib_q  <= prohib_d;
      stopped_q <= stopped_d;
      chk_q     <= chk_d;
      ist_q     <= ist_d;
      mask_q    <= mask_d;
      poll_q    <= poll_d;
      cv_q      <= cv_d;
      cc_q      <= cc_d;
      cd_q      <= cd_d;
      ack_q     <= ack_d;
      irq_q     <= irq_d;
      rd_q      <= rd_d;
      rdy_q     <= rdy_d;
      err_q     <= err_d;
    end
  end

  assign lnk.cmd_valid = cv_q;
  assign lnk.cmd_code  = cc_q;
  assign lnk.cmd_data  = cd_q;
  assign lnk.fact_ack  = ack_q;
  assign prdata        = rd_q;
  assign pready        = rdy_q;
  assign pslverr       = err_q;
  assign irq_out       = irq_q;

endmodule

/* testbench/scd_link_checker.sv */
// Concurrent checks on the link between controller and axis
`timescale 1ns/100ps
module scd_link_checker
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link signals
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [31:0] cmd_data,
  input wire logic        fact_ack,
  input wire logic [15:0] axis_status,
  input wire logic [15:0] irq_factor,
  input wire logic        drive_active,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decel stop prohibited from first acknowledge until drive ends
  logic prohib_q;
  logic prohib_d;
  always_comb begin
    prohib_d = drive_active ? prohib_q : 1'b0;
    if (fact_ack) begin
      prohib_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prohib_q <= 1'b0;
    end else begin
      prohib_q <= prohib_d;
    end
  end

  sequence s_cmd(logic [7:0] c);
    cmd_valid && cmd_code == c;
  endsequence
  sequence s_mode1_off;
    cmd_valid && cmd_code == CMD_WR_MODE1 && !cmd_data[MODE1_CEND_EN];
  endsequence

  flags_need_drive_a: assert property (
    axis_status[4:2] != 3'b000 |-> drive_active) else $error("phase flag without drive");
  phase_onehot_a: assert property (
    $onehot0(axis_status[4:2])) else $error("two phase flags at once");
  irq_follows_a: assert property (
    irq_factor[FACT_CEND] |-> ##[0:1] irq) else $error("factor set, no interrupt");
  factor_bits_a: assert property (
    (irq_factor & 16'hFFDF) == 16'h0000) else $error("unexpected factor bit");
  cend_hold_a: assert property (
    irq_factor[FACT_CEND] && !fact_ack |=> irq_factor[FACT_CEND]) else $error("factor lost");
  sudden_halt_a: assert property (
    s_cmd(CMD_SUD_STOP) |=> !drive_active) else $error("drive kept after sudden stop");
  dstop_guard_a: assert property (
    !(prohib_q && cmd_valid && cmd_code == CMD_DEC_STOP)) else $error("decel stop issued");
  cend_off_a: assert property (
    fact_ack |-> ##[0:4] s_mode1_off) else $error("end interrupt left enabled");
endmodule

/* testbench/testbench.sv */
// Bench driving the controller over APB with the axis on its link
`timescale 1ns/100ps
module testbench;
  import scd_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_out;
  logic        lim_pos_n = 1'b1;
  logic        lim_neg_n = 1'b1;
  logic [31:0] rd;
  logic        err;
  int          err_count = 0;
  int          cmp_count = 0;

  scd_link_if lnk ();
  scd_axis_dev i_scd_axis_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .lim_pos_n(lim_pos_n), .lim_neg_n(lim_neg_n), .pulse_out(), .dir_out());
  scd_host_ctl i_scd_host_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq_out), .lnk(lnk));
  scd_link_checker i_scd_link_checker (.pclk(pclk), .presetn(presetn),
    .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code), .cmd_data(lnk.cmd_data),
    .fact_ack(lnk.fact_ack), .axis_status(lnk.axis_status), .irq_factor(lnk.irq_factor),
    .drive_active(lnk.drive_active), .irq(lnk.irq));

  always #25 pclk = ~pclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Setup cycle, then access until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        stop_test();
      end
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, rd);
  endtask

  task automatic start(input logic [31:0] c, input int pre);
    apb(1'b1, REG_CTRL, c);
    repeat (pre) @(posedge pclk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (lnk.drive_active !== 1'b0) begin
      n++;
      if (n > 30000) begin
        err_count++;
        stop_test();
      end
      @(negedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(REG_SPEED, {16'h0000, RST_SPEED});
    rdc(REG_SOFTP, RST_SOFTP);
    rdc(REG_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    apb(1'b1, REG_PULSES, 32'h0000_0001);
    start(32'h0000_0001, 4);
    chk("irq masked", 32'h0000_0000, {31'h0, irq_out});
    rdc(REG_IRQ_ST, 32'h0000_0002);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_000F);
    apb(1'b1, REG_PULSES, 32'h0000_0020);
    apb(1'b1, REG_SOFTP, 32'h0000_0010);
    start(32'h0000_0001, 4);
    chk("irq raised", 32'h0000_0001, {31'h0, irq_out});
    rdc(REG_IRQ_ST, 32'h0000_0002);
    @(posedge pclk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq_out});
    apb(1'b1, REG_SOFTP, RST_SOFTP);
    apb(1'b1, REG_SPEED, 32'h0000_0110);
    start(32'h0000_0001, 12);
    wait_idle();
    rdc(REG_IRQ_ST, 32'h0000_0009);
    apb(1'b1, REG_SPEED, 32'h0000_1000);
    apb(1'b1, REG_PULSES, 32'h000F_0000);
    start(32'h0000_0001, 12);
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    rdc(REG_IRQ_ST, 32'h0000_0002);
    apb(1'b1, REG_CTRL, 32'h0000_0008);
    repeat (4) @(posedge pclk);
    rdc(REG_STATUS, 32'h0000_0000);
    rdc(REG_IRQ_ST, 32'h0000_0001);
    start(32'h0000_0001, 400);
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_idle();
    rdc(REG_IRQ_ST, 32'h0000_0009);
    start(32'h0000_0001, 400);
    lim_pos_n <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(REG_STATUS, 32'h0000_1000);
    lim_neg_n <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(REG_STATUS, 32'h0000_3000);
    lim_pos_n <= 1'b1;
    lim_neg_n <= 1'b1;
    rdc(REG_IRQ_ST, 32'h0000_0001);
    start(32'h0000_0011, 400);
    lim_pos_n <= 1'b0;
    wait_idle();
    rdc(REG_IRQ_ST, 32'h0000_000D);
    chk("done", 32'h0000_0001, {31'h0, rd[EV_DONE]});
    stop_test();
  end
endmodule
